// ### bench/i2c_host.sv
`timescale 1ns/10ps
module i2c_host (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	// bus idles released, both lines high
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// one scl phase, eight clocks keeps low time legal
	task automatic ph();
		repeat (8) @(negedge clk);
	endtask
	// start, also used as repeated start
	task automatic start();
		repeat (3) @(negedge clk);
		sda_low = 1'b0;
		ph();
		scl = 1'b1;
		ph();
		sda_low = 1'b1;
		ph();
		scl = 1'b0;
	endtask
	task automatic stop();
		repeat (3) @(negedge clk);
		sda_low = 1'b1;
		ph();
		scl = 1'b1;
		ph();
		sda_low = 1'b0;
		ph();
	endtask
	// data moves only well after scl falls
	task automatic bit1(input logic b, output logic r);
		repeat (3) @(negedge clk);
		sda_low = !b;
		ph();
		scl = 1'b1;
		ph();
		r = sda;
		scl = 1'b0;
	endtask
	// msb first, ninth bit is the acknowledge
	task automatic xfer(input logic [7:0] d, input logic n,
		output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) bit1(d[i], q[i]);
		bit1(n, a);
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] p, d,
		output logic ok);
		logic [7:0] q;
		logic a0, a1, a2;
		start();
		xfer({dev, 1'b0}, 1'b1, q, a0);
		xfer(p, 1'b1, q, a1);
		xfer(d, 1'b1, q, a2);
		stop();
		ok = (a0 === 1'b0) && (a1 === 1'b0) && (a2 === 1'b0);
	endtask
	// pointer write, repeated start, one byte read then nack
	task automatic rd(input logic [6:0] dev, input logic [7:0] p,
		output logic [7:0] d);
		logic [7:0] q;
		logic a;
		start();
		xfer({dev, 1'b0}, 1'b1, q, a);
		xfer(p, 1'b1, q, a);
		start();
		xfer({dev, 1'b1}, 1'b1, q, a);
		xfer(8'hff, 1'b1, d, a);
		stop();
	endtask
endmodule // i2c_host

// ### bench/tb.sv
`timescale 1ns/10ps
module tb;
	import led_pkg::*;
	localparam logic [6:0] DEV = {DEV_ADDR_HI, 2'b01};
	logic clock, rst_b, scl, sda, h_low, sda_oe, sdn, sir;
	logic sync, s_drv, sync_out, sync_oe, deghost, irq_n, ok, sda_out;
	logic [15:0] row_open, row_short, rows_o;
	logic [11:0] cols_o;
	logic [7:0] gc, rd;
	int n_mismatch, n_tests, n, r0, r1, r2, sy, bl, dg;
	// open-drain data line with pull-up; sync pin shared
	assign sda = !(sda_oe || h_low);
	assign sync = sync_oe ? sync_out : s_drv;
	i2c_host i_host (
		.clk(clock),
		.sda(sda),
		.scl(scl),
		.sda_low(h_low)
	);
	led_matrix_pwm_breath_driver #(.BREATH_TICK_CYC(4)) i_dut (
		.CLOCK(clock),
		.RST_B(rst_b),
		.SCL(scl),
		.SDA_IN(sda),
		.SDA_OUT(sda_out),
		.SDA_OE(sda_oe),
		.BUS_ADDR_SEL_A(1'b1),
		.BUS_ADDR_SEL_B(1'b0),
		.SHUTDOWN_IN_N(sdn),
		.SERIAL_IF_RESET_IN(sir),
		.SYNC_IN(sync),
		.SYNC_OUT(sync_out),
		.SYNC_OE(sync_oe),
		.ROW_OPEN(row_open),
		.ROW_SHORT(row_short),
		.COLUMN_SWITCH_OUTPUTS(cols_o),
		.ROW_CURRENT_OUTPUTS(rows_o),
		.GLOBAL_CURRENT(gc),
		.DEGHOST_DISCHARGE(deghost),
		.IRQ_OUT_N(irq_n)
	);
	// 40 MHz system clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic chk(input string s, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wreg(input logic [7:0] p, d);
		i_host.wr(DEV, p, d, ok);
		chk("ack", 1, ok);
	endtask
	task automatic rreg(input logic [7:0] p, e);
		i_host.rd(DEV, p, rd);
		chk($sformatf("reg %h", p), e, rd);
	endtask
	task automatic print_verdict();
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard, well beyond the expected run
	initial begin
		repeat (90000) @(posedge clock);
		n_mismatch++;
		print_verdict();
	end
	// main sequence
	initial begin
		rst_b = 1'b0;
		sdn = 1'b1;
		sir = 1'b0;
		s_drv = 1'b0;
		row_open = 16'h0002;
		row_short = 16'h0001;
		repeat (4) @(negedge clock);
		rst_b = 1'b1;
		repeat (3) @(negedge clock);
		chk("cols", 0, cols_o);
		chk("irq", 1, irq_n);
		chk("sync oe", 0, sync_oe);
		chk("gc", 0, gc);
		chk("sda out", 0, sda_out);
		i_host.wr(DEV ^ 7'h02, A_PAGE, 8'h03, ok);
		chk("bad addr", 0, ok);
		sir = 1'b1;
		i_host.wr(DEV, A_PAGE, 8'h03, ok);
		chk("if reset", 0, ok);
		sir = 1'b0;
		wreg(A_PAGE, {6'h00, PG_CTL});
		rreg(A_CFG, REG_RST);
		rreg(A_ISEL, REG_RST);
		wreg(8'he0, 8'h5a);
		rreg(8'he0, 8'h00);
		wreg(A_GCC, 8'ha5);
		chk("gc idle", 0, gc);
		// duties for column 0, rows 0 and 1, row 2 left at zero
		wreg(A_PAGE, {6'h00, PG_PWM});
		wreg(8'h00, 8'h80);
		wreg(8'h01, 8'hff);
		wreg(A_PAGE, {6'h00, PG_CTL});
		wreg(A_CFG, 8'h17);
		chk("master oe", 1, sync_oe);
		chk("gc", 8'ha5, gc);
		// column 0 slot, then blanking up to column 1
		for (n = 0; n < 2000 && cols_o[0] !== 1'b1; n++) @(negedge clock);
		n = 0;
		while (cols_o[0] === 1'b1 && n < 9999) begin
			n++;
			r0 += rows_o[0];
			r1 += rows_o[1];
			r2 += (rows_o[2] !== 1'b0);
			sy += sync_out;
			@(negedge clock);
		end
		chk("drive", PWM_STEPS * PWM_DIV, n);
		chk("row0", 128 * PWM_DIV, r0);
		chk("row1", 255 * PWM_DIV, r1);
		chk("row2", 0, r2);
		chk("sync out", n, sy);
		while (cols_o === 12'h000 && bl < 999) begin
			bl++;
			dg += deghost;
			r2 += (rows_o !== 16'h0000);
			@(negedge clock);
		end
		chk("blank", BLANK_CYC, bl);
		chk("deghost", BLANK_CYC, dg);
		chk("blank rows", 0, r2);
		chk("next col", 12'h002, cols_o);
		// shutdown and resume
		sdn = 1'b0;
		repeat (8) @(negedge clock);
		chk("sd gc", 0, gc);
		chk("sd cols", 0, cols_o);
		sdn = 1'b1;
		repeat (8) @(negedge clock);
		chk("gc back", 8'ha5, gc);
		// open row 1 and short row 0 flagged, interrupt gated by enables
		rreg(A_FLT, 8'h03);
		chk("irq masked", 1, irq_n);
		wreg(A_ISEL, 8'h09);
		chk("irq on", 0, irq_n);
		wreg(A_CFG, 8'h07);
		wreg(A_IST, 8'h08);
		chk("irq clr", 1, irq_n);
		// pattern one: quick ramps, loop end at off, one pass
		wreg(A_BP + 8'h05, {6'h00, PH_OFF});
		wreg(A_BP + 8'h06, 8'h01);
		wreg(A_PAGE, {6'h00, PG_MODE});
		wreg(8'h00, 8'h01);
		wreg(A_PAGE, {6'h00, PG_CTL});
		wreg(A_CFG, 8'h0f);
		for (n = 0; n < 4000 && irq_n !== 1'b0; n++) @(negedge clock);
		chk("breath irq", 0, irq_n);
		rreg(A_IST, 8'h01);
		rreg(A_BUSY, 8'h06);
		// slave mode waits for the sync pin
		wreg(A_CFG, 8'h01);
		chk("slave oe", 0, sync_oe);
		repeat (6000) @(negedge clock);
		chk("slave wait", 0, cols_o);
		for (n = 0; n < 400 && cols_o === 12'h000; n++) begin
			repeat (4) @(negedge clock);
			s_drv = !s_drv;
		end
		s_drv = 1'b0;
		chk("slave run", 1, |cols_o);
		print_verdict();
	end
endmodule // tb

// ### rtl/breath_engine.sv
`timescale 1ns/10ps
module breath_engine (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic start,
	input led_pkg::breath_cfg_t cfg,
	output logic [7:0] level,
	output logic busy,
	output logic done
);
	import led_pkg::*;
	typedef enum logic [4:0] {
		B_IDLE = 5'b00001,
		B_RISE = 5'b00010,
		B_HOLD = 5'b00100,
		B_FALL = 5'b01000,
		B_OFF = 5'b10000
	} bstate_t;
	bstate_t st;
	logic [6:0] lvl;
	logic [7:0] dwell;
	logic [7:0] loops;
	logic [1:0] ph;
	logic ph_end;
	logic [13:0] sq;

	function automatic bstate_t ph_state(input logic [1:0] p);
		case (p)
			PH_RISE: return B_RISE;
			PH_HOLD: return B_HOLD;
			PH_FALL: return B_FALL;
			default: return B_OFF;
		endcase
	endfunction

	function automatic logic [6:0] ph_lvl(input logic [1:0] p);
		return (p == PH_HOLD || p == PH_FALL) ? LVL_TOP : 7'h00;
	endfunction

	// phase in progress and its end condition
	always_comb begin
		ph = PH_OFF;
		ph_end = 1'b0;
		case (st)
			B_RISE: begin
				ph = PH_RISE;
				ph_end = lvl == LVL_TOP && dwell == cfg.rise;
			end
			B_HOLD: begin
				ph = PH_HOLD;
				ph_end = dwell == cfg.hold;
			end
			B_FALL: begin
				ph = PH_FALL;
				ph_end = lvl == 7'h00 && dwell == cfg.fall;
			end
			B_OFF: ph_end = dwell == cfg.off;
			default: ph_end = 1'b0;
		endcase
	end

	// phase sequencing with loop window and repeat count
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (!rst_b) begin
			st <= B_IDLE;
			lvl <= 7'h00;
			dwell <= 8'h00;
			loops <= 8'h00;
		end else if (start) begin
			st <= B_RISE;
			lvl <= 7'h00;
			dwell <= 8'h00;
			loops <= 8'h00;
		end else if (tick && st != B_IDLE) begin
			if (!ph_end) begin
				if ((st == B_RISE && dwell == cfg.rise) ||
				    (st == B_FALL && dwell == cfg.fall)) begin
					dwell <= 8'h00;
					lvl <= (st == B_RISE) ? lvl + 7'h01 : lvl - 7'h01;
				end else begin
					dwell <= dwell + 8'h01;
				end
			end else if (ph == cfg.lend) begin
				dwell <= 8'h00;
				if (cfg.reps != 8'h00 && 8'(loops + 8'h01) == cfg.reps) begin
					st <= B_IDLE;
					done <= 1'b1;
				end else begin
					loops <= loops + 8'h01;
					st <= ph_state(cfg.lstart);
					lvl <= ph_lvl(cfg.lstart);
				end
			end else begin
				dwell <= 8'h00;
				st <= ph_state(ph + 2'h1);
				lvl <= ph_lvl(ph + 2'h1);
			end
		end
	end

	// gamma curve over 128 levels
	assign sq = 14'(lvl) * 14'(lvl);
	assign level = sq[13:6];
	assign busy = st != B_IDLE;

	a_done_idle: assert property (@(posedge clk) disable iff (!rst_b)
		done |-> !busy && $past(busy)) else $error("done without stop");
	a_rise_hold: assert property (@(posedge clk) disable iff (!rst_b)
		st == B_RISE && tick && ph_end && cfg.lend != PH_RISE && !start
		|=> st == B_HOLD && lvl == LVL_TOP) else $error("bad rise end");
endmodule // breath_engine

// ### rtl/led_matrix_pwm_breath_driver.sv
// Summary of operation
// - each LED dimmed by own 8-bit duty
// - three breath patterns, per-LED selectable or fixed
// - rise, hold, fall, off, loop points, repeats
// - 128-level gamma breathing, levels readable
// - per-LED open/short flags readable by host
// - twelve columns scanned one at a time
// - interrupt low on enabled event, F0 selects
// - interrupt when breath loop sequence completes
// - global 256-step current scale for all
// - shutdown while shutdown input low
// - serial interface held reset while input high
// - config 00 picks master or slave sync
// - de-ghost discharge during scan blanking
// - 8 us blanking in master mode, column and row outputs off
`timescale 1ns/10ps
module led_matrix_pwm_breath_driver #(
	parameter int BREATH_TICK_CYC = led_pkg::BREATH_TICK_NS / led_pkg::CLK_NS
) (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic BUS_ADDR_SEL_A,
	input wire logic BUS_ADDR_SEL_B,
	input wire logic SHUTDOWN_IN_N,
	input wire logic SERIAL_IF_RESET_IN,
	input wire logic SYNC_IN,
	output logic SYNC_OUT,
	output logic SYNC_OE,
	input wire logic [15:0] ROW_OPEN,
	input wire logic [15:0] ROW_SHORT,
	output logic [11:0] COLUMN_SWITCH_OUTPUTS,
	output logic [15:0] ROW_CURRENT_OUTPUTS,
	output logic [7:0] GLOBAL_CURRENT,
	output logic DEGHOST_DISCHARGE,
	output logic IRQ_OUT_N
);
	import led_pkg::*;
	typedef enum logic [6:0] {
		I_IDLE = 7'b0000001, I_ADDR = 7'b0000010, I_AACK = 7'b0000100,
		I_WR = 7'b0001000, I_WACK = 7'b0010000, I_RD = 7'b0100000,
		I_RACK = 7'b1000000
	} i2c_t;
	typedef enum logic [1:0] {S_BLANK = 2'b01, S_DRIVE = 2'b10} scan_t;
	logic [38:0] s1, s2;
	logic scl, sda, sa, sb, sdn, srst, syn, scl_d, sda_d, syn_d;
	logic [15:0] opn, sht;
	i2c_t ist_q;
	logic [7:0] sh, ptr, rdata;
	logic [3:0] bitc;
	logic first, ack_drv, nack, wr;
	logic [7:0] cfg, gcc, isel;
	logic [1:0] page;
	logic [7:0] bp [PATS][BP_NUM];
	logic [7:0] pwm [LEDS];
	logic [1:0] mode [LEDS];
	logic [LEDS-1:0] flt;
	logic [3:0] irq_st;
	logic [7:0] level [PATS];
	logic [PATS-1:0] busy, done;
	logic brun_d, tick, act, master, drive, slot_end;
	logic [23:0] tick_cnt;
	scan_t st;
	logic [3:0] col;
	logic [15:0] cnt;
	logic [7:0] step;
	logic [7:0] duty [ROWS];
	logic [15:0] fvec;
	logic [7:0] boff, foff;

	// two-stage sampling of every pin input except RST_B
	always_ff @(posedge CLOCK) begin
		s1 <= {SCL, SDA_IN, BUS_ADDR_SEL_A, BUS_ADDR_SEL_B, SHUTDOWN_IN_N,
			SERIAL_IF_RESET_IN, SYNC_IN, ROW_OPEN, ROW_SHORT};
		s2 <= s1;
		scl_d <= scl;
		sda_d <= sda;
		syn_d <= syn;
	end
	assign {scl, sda, sa, sb, sdn, srst, syn, opn, sht} = s2;
	assign act = sdn && cfg[CB_RUN];
	assign master = cfg[CB_MASTER];
	assign drive = st == S_DRIVE;

	// serial slave: start, address, pointer, data, ack
	always_ff @(posedge CLOCK) begin
		wr <= 1'b0;
		if (!RST_B || srst || (scl && scl_d && !sda_d && sda)) begin
			ist_q <= I_IDLE;
			SDA_OE <= 1'b0;
			bitc <= 4'h0;
			ack_drv <= 1'b0;
			first <= 1'b1;
			nack <= 1'b0;
			if (!RST_B) begin
				sh <= 8'h00;
				ptr <= 8'h00;
			end
		end else if (scl && scl_d && sda_d && !sda) begin
			ist_q <= I_ADDR;
			SDA_OE <= 1'b0;
			bitc <= 4'h0;
			first <= 1'b1;
		end else if (scl && !scl_d) begin
			if (ist_q == I_ADDR || ist_q == I_WR) begin
				sh <= {sh[6:0], sda};
				bitc <= bitc + 4'h1;
				if (bitc == 4'h7) begin
					bitc <= 4'h0;
					if (ist_q == I_ADDR) begin
						nack <= sda;
						ist_q <= ({sh[6:2], sh[1:0]} ==
							{DEV_ADDR_HI, sb, sa}) ? I_AACK : I_IDLE;
					end else begin
						ist_q <= I_WACK;
						first <= 1'b0;
						if (first) ptr <= {sh[6:0], sda};
						else wr <= 1'b1;
					end
				end
			end else if (ist_q == I_RACK) begin
				nack <= sda;
			end
		end else if (!scl && scl_d) begin
			case (ist_q)
				I_AACK, I_WACK: begin
					ack_drv <= !ack_drv;
					SDA_OE <= !ack_drv;
					if (ack_drv && ist_q == I_WACK) ist_q <= I_WR;
					if (ack_drv && ist_q == I_AACK) ist_q <= nack ? I_RD : I_WR;
					if (ack_drv && ist_q == I_AACK && nack) begin
						SDA_OE <= !rdata[7];
						sh <= {rdata[6:0], 1'b0};
						bitc <= 4'h1;
						ptr <= ptr + 8'h01;
					end
				end
				I_RD: begin
					if (bitc == 4'h8) begin
						SDA_OE <= 1'b0;
						ist_q <= I_RACK;
					end else begin
						SDA_OE <= !sh[7];
						sh <= {sh[6:0], 1'b0};
						bitc <= bitc + 4'h1;
					end
				end
				I_RACK: begin
					if (nack) begin
						ist_q <= I_IDLE;
					end else begin
						ist_q <= I_RD;
						SDA_OE <= !rdata[7];
						sh <= {rdata[6:0], 1'b0};
						bitc <= 4'h1;
						ptr <= ptr + 8'h01;
					end
				end
				default: ;
			endcase
		end
		if (wr) ptr <= ptr + 8'h01;
	end
	always_ff @(posedge CLOCK) SDA_OUT <= 1'b0;

	assign boff = ptr - A_BP;
	assign foff = ptr - A_FLT;
	// read mux over pages
	always_comb begin
		rdata = 8'h00;
		case (page)
			PG_PWM: if (ptr < 8'(LEDS)) rdata = pwm[ptr];
			PG_MODE: if (ptr < 8'(LEDS)) rdata = {6'h00, mode[ptr]};
			PG_CTL: begin
				if (ptr == A_CFG) rdata = cfg;
				if (ptr == A_GCC) rdata = gcc;
				if (ptr == A_IST) rdata = {4'h0, irq_st};
				if (ptr == A_BUSY) rdata = {5'h00, busy};
				if (ptr >= A_LVL && ptr < A_LVL + 8'(PATS))
					rdata = level[2'(ptr - A_LVL)];
				if (boff < BP_BYTES && boff[2:0] != 3'h7)
					rdata = bp[boff[4:3]][boff[2:0]];
				if (foff < FLT_BYTES) rdata = flt[foff*8 +: 8];
				if (ptr == A_ISEL) rdata = isel;
			end
			default: rdata = 8'h00;
		endcase
		if (ptr == A_PAGE) rdata = {6'h00, page};
	end

	// register writes
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			cfg <= REG_RST;
			gcc <= REG_RST;
			isel <= REG_RST;
			page <= PG_PWM;
			for (int i = 0; i < LEDS; i++) begin
				pwm[i] <= REG_RST;
				mode[i] <= 2'h0;
			end
			for (int p = 0; p < PATS; p++)
				for (int k = 0; k < BP_NUM; k++) bp[p][k] <= REG_RST;
		end else if (wr) begin
			if (ptr == A_PAGE) page <= sh[1:0];
			else if (page == PG_PWM && ptr < 8'(LEDS)) pwm[ptr] <= sh;
			else if (page == PG_MODE && ptr < 8'(LEDS)) mode[ptr] <= sh[1:0];
			else if (page == PG_CTL) begin
				if (ptr == A_CFG) cfg <= sh;
				if (ptr == A_GCC) gcc <= sh;
				if (ptr == A_ISEL) isel <= sh;
				if (boff < BP_BYTES && boff[2:0] != 3'h7)
					bp[boff[4:3]][boff[2:0]] <= sh;
			end
		end
	end

	// breathing tick and pattern engines
	always_ff @(posedge CLOCK) begin
		tick <= 1'b0;
		brun_d <= RST_B && cfg[CB_BREATH];
		if (!RST_B || tick_cnt == 24'(BREATH_TICK_CYC - 1)) begin
			tick_cnt <= 24'h000000;
			tick <= RST_B;
		end else begin
			tick_cnt <= tick_cnt + 24'h000001;
		end
	end
	for (genvar p = 0; p < PATS; p++) begin : g_pat
		breath_engine u_eng (
			.clk(CLOCK), .rst_b(RST_B), .tick(tick),
			.start(cfg[CB_BREATH] && !brun_d),
			.cfg('{bp[p][0], bp[p][1], bp[p][2], bp[p][3], bp[p][4][1:0],
				bp[p][5][1:0], bp[p][6]}),
			.level(level[p]), .busy(busy[p]), .done(done[p]));
	end

	// per-row duty: fixed or scaled by chosen pattern
	always_comb begin
		logic [7:0] idx;
		logic [15:0] prod;
		idx = 8'h00;
		prod = 16'h0000;
		for (int r = 0; r < ROWS; r++) begin
			idx = 8'(col * ROWS + r);
			prod = (mode[idx] == 2'h0) ? {pwm[idx], 8'hff} :
				16'(pwm[idx]) * 16'(level[mode[idx] - 2'h1]);
			duty[r] = prod[15:8];
		end
	end

	// column scan: blank, then 256 pwm steps per column
	assign slot_end = drive && cnt == PWM_LAST && step == 8'hff;
	always_ff @(posedge CLOCK) begin
		if (!RST_B || !act) begin
			st <= S_BLANK;
			col <= 4'h0;
			cnt <= 16'h0000;
			step <= 8'h00;
		end else case (st)
			S_BLANK: begin
				if (master ? cnt == BLANK_LAST : syn && !syn_d) begin
					st <= S_DRIVE;
					cnt <= 16'h0000;
					step <= 8'h00;
				end else if (cnt != BLANK_LAST) cnt <= cnt + 16'h0001;
			end
			S_DRIVE: begin
				cnt <= (cnt == PWM_LAST) ? 16'h0000 : cnt + 16'h0001;
				if (cnt == PWM_LAST) step <= step + 8'h01;
				if (slot_end) begin
					st <= S_BLANK;
					col <= (col == 4'(COLS - 1)) ? 4'h0 : col + 4'h1;
				end
			end
			default: st <= S_BLANK;
		endcase
	end

	// fault capture at the end of each column slot
	always_comb
		for (int r = 0; r < ROWS; r++)
			fvec[r] = (opn[r] || sht[r]) && duty[r] != 8'h00;
	always_ff @(posedge CLOCK) begin
		if (!RST_B) flt <= '0;
		else if (slot_end && cfg[CB_DETECT]) flt[col*ROWS +: ROWS] <= fvec;
	end

	// sticky status, set wins over write-one clear
	always_ff @(posedge CLOCK) begin
		if (!RST_B) irq_st <= 4'h0;
		else irq_st <= (irq_st & ~((wr && page == PG_CTL && ptr == A_IST) ?
			sh[3:0] : 4'h0)) | {slot_end && cfg[CB_DETECT] && |fvec, done};
	end

	// registered pin outputs
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			COLUMN_SWITCH_OUTPUTS <= 12'h000;
			ROW_CURRENT_OUTPUTS <= 16'h0000;
			GLOBAL_CURRENT <= 8'h00;
			DEGHOST_DISCHARGE <= 1'b0;
			SYNC_OUT <= 1'b0;
			SYNC_OE <= 1'b0;
			IRQ_OUT_N <= 1'b1;
		end else begin
			COLUMN_SWITCH_OUTPUTS <= (drive && act) ? 12'h001 << col : 12'h000;
			for (int r = 0; r < ROWS; r++)
				ROW_CURRENT_OUTPUTS[r] <= drive && act && step < duty[r];
			GLOBAL_CURRENT <= act ? gcc : 8'h00;
			DEGHOST_DISCHARGE <= act && !drive && cfg[CB_DEGHOST];
			SYNC_OUT <= master && drive;
			SYNC_OE <= master;
			IRQ_OUT_N <= !(|(irq_st & isel[3:0]));
		end
	end

	a_irq_level: assert property (@(posedge CLOCK) disable iff (!RST_B)
		1'b1 |=> IRQ_OUT_N == !(|($past(irq_st) & $past(isel[3:0]))))
		else $error("irq pin mismatch");
	a_done_irq: assert property (@(posedge CLOCK) disable iff (!RST_B)
		done[0] && isel[0] |=> ##1 !IRQ_OUT_N) else $error("no irq");
	a_cols_one: assert property (@(posedge CLOCK) disable iff (!RST_B)
		$onehot0(COLUMN_SWITCH_OUTPUTS)) else $error("two columns");
	a_blank_off: assert property (@(posedge CLOCK) disable iff (!RST_B)
		!drive |=> COLUMN_SWITCH_OUTPUTS == 12'h000 &&
		ROW_CURRENT_OUTPUTS == 16'h0000) else $error("on in blank");
	a_blank_len: assert property (@(posedge CLOCK) disable iff (!RST_B)
		master && act && $fell(drive) |-> !drive [*8]) else $error("short");
	a_shutdown: assert property (@(posedge CLOCK) disable iff (!RST_B)
		!sdn |=> COLUMN_SWITCH_OUTPUTS == 12'h000 && GLOBAL_CURRENT == 8'h00)
		else $error("lit in shutdown");
	a_bus_reset: assert property (@(posedge CLOCK) disable iff (!RST_B)
		srst |=> ist_q == I_IDLE && !SDA_OE) else $error("bus not reset");
	a_sync_dir: assert property (@(posedge CLOCK) disable iff (!RST_B)
		1'b1 |=> SYNC_OE == $past(master)) else $error("sync dir");
	a_gcc_out: assert property (@(posedge CLOCK) disable iff (!RST_B)
		act |=> GLOBAL_CURRENT == $past(gcc)) else $error("gcc");
	a_col_step: assert property (@(posedge CLOCK) disable iff (!RST_B)
		slot_end && act && col != 4'(COLS - 1) |=> col == $past(col) + 4'h1)
		else $error("column order");
endmodule // led_matrix_pwm_breath_driver

// ### rtl/led_pkg.sv
package led_pkg;
	localparam int COLS = 12;
	localparam int ROWS = 16;
	localparam int LEDS = 192;
	localparam int PATS = 3;
	localparam int BP_NUM = 7;
	// register offsets, control page
	localparam logic [7:0] A_CFG = 8'h00;
	localparam logic [7:0] A_GCC = 8'h01;
	localparam logic [7:0] A_IST = 8'h02;
	localparam logic [7:0] A_BUSY = 8'h03;
	localparam logic [7:0] A_LVL = 8'h04;
	localparam logic [7:0] A_BP = 8'h08;
	localparam logic [7:0] A_FLT = 8'h20;
	localparam logic [7:0] A_ISEL = 8'hf0;
	localparam logic [7:0] A_PAGE = 8'hfd;
	localparam logic [7:0] FLT_BYTES = 8'h18;
	localparam logic [7:0] BP_BYTES = 8'h18;
	localparam logic [1:0] PG_PWM = 2'h0;
	localparam logic [1:0] PG_MODE = 2'h1;
	localparam logic [1:0] PG_CTL = 2'h3;
	localparam logic [7:0] REG_RST = 8'h00;
	// function_configuration bits
	localparam int CB_RUN = 0;
	localparam int CB_MASTER = 1;
	localparam int CB_DEGHOST = 2;
	localparam int CB_BREATH = 3;
	localparam int CB_DETECT = 4;
	localparam int IB_FLT = 3;
	localparam logic [4:0] DEV_ADDR_HI = 5'h14;
	// breathing phases and curve
	localparam logic [1:0] PH_RISE = 2'h0;
	localparam logic [1:0] PH_HOLD = 2'h1;
	localparam logic [1:0] PH_FALL = 2'h2;
	localparam logic [1:0] PH_OFF = 2'h3;
	localparam logic [6:0] LVL_TOP = 7'h7f;
	// scan timing
	localparam int CLK_NS = 25;
	localparam int SCAN_NS = 128000;
	localparam int BLANK_NS = 8000;
	localparam int PWM_STEPS = 256;
	localparam int BREATH_TICK_NS = 1000000;
	localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
	localparam int PWM_DIV = (SCAN_NS - BLANK_NS) / PWM_STEPS / CLK_NS;
	localparam logic [15:0] BLANK_LAST = 16'(BLANK_CYC - 1);
	localparam logic [15:0] PWM_LAST = 16'(PWM_DIV - 1);
	typedef struct packed {
		logic [7:0] rise;
		logic [7:0] hold;
		logic [7:0] fall;
		logic [7:0] off;
		logic [1:0] lstart;
		logic [1:0] lend;
		logic [7:0] reps;
	} breath_cfg_t;
endpackage
